// ---- rtl/embedded_flash_protect_control.sv ----
/*
  Flash protection gate and core-side flash control registers.
  Assumes a one-cycle read port and external flash and host-lock logic.
*/
//
// Contract
// - Core reads of the flash are always granted once the limits are loaded.
// - One protect bit per 8 Kbyte block, bit i at i times 0x2000.
// - Protect bit 0 blocks core program/erase; 1 allows it.
// - Block protect register resets to zero, all blocks protected.
// - Blocks in core or host boot areas stay protected regardless.
// - Factory area and protection word always refuse core writes.
// - Core accesses never get the special whole-array erase.
// - Host limited by protection word and core; never Information Block.
// - Contents protect not all ones: debug refused, held reset in a debug environment until special erase done, special erase only.
// - Contents protect all ones: debug reads all, writes all but factory page.
// - Parallel interface follows debug protection, special erase only.
// - Index holds byte address; word access only at even index.
// - Data register moves byte or word at the indexed location.
// - Control resets to zero; writes ignored while host lock set.
// - Bit 4 enables buffer-not-full interrupt request; off when 0.
// - Bit 5 enables core program only with erase selects clear.
// - Bit 6 alone makes a core write erase its page.
// - Bit 7 alone erases a section; info address adds main section.
// - Bit 8 zero verifies after program/erase; one skips verify.
// - Protected core writes are discarded and flag a violation.
// - Protection word read at reset sets the contents protect limit; boot areas come from their own inputs.
// - Contents protect field bits 9-7; only 111 is open.
// - Buffer full status 0 while a buffer word is empty.
`timescale 1ns/100ps
module embedded_flash_protect_control (
  input wire logic clock,
  input wire logic nrst,
  // core register port
  input wire logic [23:0] regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regByte,
  output logic [15:0] regReadData,
  output logic regWordFault,
  // flash requests from the four sources
  input flash_protect_pkg::flash_request_type request,
  output flash_protect_pkg::flash_decision_type decision,
  output logic writeViolation,
  // protection word and boot areas at reset
  input wire logic [15:0] protectionWord,
  input wire logic [4:0] coreBootBlocks,
  input wire logic [4:0] hostBootBlocks,
  input wire logic [15:0] hostWindow,
  input wire logic debugEnvironment,
  input wire logic specialEraseDone,
  output logic holdInReset,
  output logic limitsLoaded,
  // shared memory and flash array state
  input wire logic hostLock,
  input wire logic doubleBufferFull,
  input wire logic [15:0] infoReadData,
  output logic [7:0] infoAddr,
  output logic [15:0] infoWriteData,
  output logic infoWrite,
  output logic infoRead,
  output logic infoByte,
  // control outputs
  output logic flashLowPower,
  output logic bufferIrq,
  output logic verifyEnable
);

  ////////////////////////////////////////////////////////////////////
  // reset release

  logic rstMetaQ;
  logic rstSyncQ;
  logic hostLockMetaQ;
  logic hostLockQ;
  logic bufferFullMetaQ;
  logic bufferFullQ;
  logic debugEnvMetaQ;
  logic debugEnvQ;
  logic eraseDoneMetaQ;
  logic eraseDoneQ;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMetaQ <= 1'b0;
      rstSyncQ <= 1'b0;
    end
    else
    begin
      rstMetaQ <= 1'b1;
      rstSyncQ <= rstMetaQ;
    end
  end

  // two-stage capture of signals from other domains
  always_ff @(posedge clock or negedge rstSyncQ)
  begin
    if (!rstSyncQ)
    begin
      hostLockMetaQ <= 1'b1;
      hostLockQ <= 1'b1;
      bufferFullMetaQ <= 1'b1;
      bufferFullQ <= 1'b1;
      debugEnvMetaQ <= 1'b0;
      debugEnvQ <= 1'b0;
      eraseDoneMetaQ <= 1'b0;
      eraseDoneQ <= 1'b0;
    end
    else
    begin
      hostLockMetaQ <= hostLock;
      hostLockQ <= hostLockMetaQ;
      bufferFullMetaQ <= doubleBufferFull;
      bufferFullQ <= bufferFullMetaQ;
      debugEnvMetaQ <= debugEnvironment;
      debugEnvQ <= debugEnvMetaQ;
      eraseDoneMetaQ <= specialEraseDone;
      eraseDoneQ <= eraseDoneMetaQ;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // protection word

  flash_protect_pkg::protection_limits_type limits;
  logic loaded;

  protection_word_loader wordLoader (
    .clock(clock),
    .rstN(rstSyncQ),
    .protectionWord(protectionWord),
    .coreBootBlocksIn(coreBootBlocks),
    .hostBootBlocksIn(hostBootBlocks),
    .limits(limits),
    .loaded(loaded)
  );

  ////////////////////////////////////////////////////////////////////
  // register decode

  logic [7:0] indexQ;
  logic [7:0] indexD;
  logic [15:0] blockProtectQ;
  logic [15:0] blockProtectD;
  logic [15:0] controlQ;
  logic [15:0] controlD;
  logic [15:0] readDataQ;
  logic [15:0] readDataD;
  logic wordFaultQ;
  logic eraseWaitQ;
  logic eraseWaitD;

  wire logic hitIndex;
  wire logic hitData;
  wire logic hitProtect;
  wire logic hitControl;
  wire logic wordMisaligned;
  wire logic dataAllowed;
  wire logic factoryArea;
  wire logic contentsOpen;

  assign hitIndex = regAddr == flash_protect_pkg::INFO_BLOCK_INDEX_ADDR;
  assign hitData = regAddr == flash_protect_pkg::INFO_BLOCK_DATA_ADDR;
  assign hitProtect = regAddr == flash_protect_pkg::CORE_BLOCK_WRITE_PROTECT_ADDR;
  assign hitControl = regAddr == flash_protect_pkg::FLASH_OPERATION_CONTROL_ADDR;

  // word transfers through the window need an even index
  assign wordMisaligned = !regByte && indexQ[0];
  assign dataAllowed = hitData && !wordMisaligned;
  // upper half of the Information Block (address bit 7 set) holds factory data and the word
  assign factoryArea = request.infoBlock && request.addr[7];
  assign contentsOpen = limits.contentsProtect == flash_protect_pkg::CONTENTS_OPEN;

  assign indexD = (regWrite && hitIndex) ? regWriteData[7:0] : indexQ;
  assign blockProtectD = (regWrite && hitProtect) ? regWriteData : blockProtectQ;
  assign controlD = (regWrite && hitControl && !hostLockQ)
    ? (regWriteData & flash_protect_pkg::CONTROL_WRITE_MASK) : controlQ;

  always_comb
  begin
    readDataD = 16'h0000;
    if (regRead)
    begin
      if (hitIndex)
        readDataD = {8'h00, indexQ};
      else if (dataAllowed)
        readDataD = regByte ? {8'h00, infoReadData[7:0]} : infoReadData;
      else if (hitProtect)
        readDataD = blockProtectQ;
      else if (hitControl)
        readDataD = controlQ;
    end
  end

  // debug environments sit in reset until a special erase finishes
  assign eraseWaitD = eraseWaitQ ? !eraseDoneQ : 1'b0;

  always_ff @(posedge clock or negedge rstSyncQ)
  begin
    if (!rstSyncQ)
    begin
      indexQ <= flash_protect_pkg::INDEX_RESET;
      blockProtectQ <= flash_protect_pkg::BLOCK_PROTECT_RESET;
      controlQ <= flash_protect_pkg::CONTROL_RESET;
      readDataQ <= 16'h0000;
      wordFaultQ <= 1'b0;
      eraseWaitQ <= 1'b1;
    end
    else
    begin
      indexQ <= indexD;
      blockProtectQ <= blockProtectD;
      controlQ <= controlD;
      readDataQ <= readDataD;
      wordFaultQ <= (regRead || regWrite) && hitData && wordMisaligned;
      eraseWaitQ <= eraseWaitD;
    end
  end

  assign regReadData = readDataQ;
  assign regWordFault = wordFaultQ;

  ////////////////////////////////////////////////////////////////////
  // Information Block window

  logic [15:0] infoWriteDataQ;
  logic infoWriteQ;
  logic infoReadQ;
  logic infoByteQ;

  always_ff @(posedge clock or negedge rstSyncQ)
  begin
    if (!rstSyncQ)
    begin
      infoWriteDataQ <= 16'h0000;
      infoWriteQ <= 1'b0;
      infoReadQ <= 1'b0;
      infoByteQ <= 1'b0;
    end
    else
    begin
      infoWriteDataQ <= regWrite ? regWriteData : infoWriteDataQ;
      infoWriteQ <= regWrite && dataAllowed;
      infoReadQ <= regRead && dataAllowed;
      infoByteQ <= regByte;
    end
  end

  assign infoAddr = indexQ;
  assign infoWriteData = infoWriteDataQ;
  assign infoWrite = infoWriteQ;
  assign infoRead = infoReadQ;
  assign infoByte = infoByteQ;

  ////////////////////////////////////////////////////////////////////
  // access decision

  flash_protect_pkg::flash_request_type gatedRequest;
  flash_protect_pkg::flash_decision_type rawDecision;
  wire logic sourceIsExternal;

  assign sourceIsExternal = request.source == flash_protect_pkg::SRC_DEBUG
    || request.source == flash_protect_pkg::SRC_PARALLEL;
  // nothing is granted before the limits exist
  always_comb
  begin
    gatedRequest = request;
    gatedRequest.valid = request.valid && loaded;
  end

  access_arbiter arbiter (
    .request(gatedRequest),
    .limits(limits),
    .blockProtect(blockProtectQ),
    .control(controlQ),
    .hostWindow(hostWindow),
    .factoryArea(factoryArea),
    .decision(rawDecision)
  );

  assign decision = rawDecision;
  assign writeViolation = rawDecision.reject && request.write
    && request.source == flash_protect_pkg::SRC_CORE;
  assign holdInReset = !loaded
    || (debugEnvQ && !contentsOpen && eraseWaitQ && sourceIsExternal);
  assign limitsLoaded = loaded;

  ////////////////////////////////////////////////////////////////////
  // control outputs

  assign flashLowPower = controlQ[flash_protect_pkg::LOW_POWER_BIT];
  assign bufferIrq = controlQ[flash_protect_pkg::BUFFER_IRQ_BIT] && !bufferFullQ;
  assign verifyEnable = !controlQ[flash_protect_pkg::VERIFY_DISABLE_BIT];

endmodule

// ---- pkg/flash_protect_pkg.sv ----
/*
  Constants, field layouts and carrier types for the flash protection
  and core-side control block. Assumes a 16-bit core register port.
*/
package flash_protect_pkg;

  // register byte addresses
  localparam logic [23:0] INFO_BLOCK_INDEX_ADDR = 24'h00F880;
  localparam logic [23:0] INFO_BLOCK_DATA_ADDR = 24'h00F882;
  localparam logic [23:0] CORE_BLOCK_WRITE_PROTECT_ADDR = 24'h00F890;
  localparam logic [23:0] FLASH_OPERATION_CONTROL_ADDR = 24'h00F8C0;

  // reset values
  localparam logic [15:0] BLOCK_PROTECT_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [7:0] INDEX_RESET = 8'h00;

  // control register fields
  localparam int LOW_POWER_BIT = 0;
  localparam int BUFFER_IRQ_BIT = 4;
  localparam int PROGRAM_BIT = 5;
  localparam int PAGE_ERASE_BIT = 6;
  localparam int SECTION_ERASE_BIT = 7;
  localparam int VERIFY_DISABLE_BIT = 8;
  localparam logic [15:0] CONTROL_WRITE_MASK = 16'h01F1;

  // protection word field
  localparam int CONTENTS_PROTECT_LSB = 7;
  localparam int CONTENTS_PROTECT_MSB = 9;
  localparam logic [2:0] CONTENTS_OPEN = 3'h7;

  // main array geometry
  localparam int BLOCK_ADDR_LSB = 13;
  localparam int MAIN_ADDR_WIDTH = 17;
  localparam int BOOT_BLOCKS_WIDTH = 5;

  // reset sequence timing
  localparam int PWORD_LOAD_CYCLES = 2;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_PAGE_ERASE = 3'h2,
    OP_SECTION_ERASE = 3'h3,
    OP_SPECIAL_ERASE = 3'h4
  } flash_op_type;

  typedef enum logic [1:0] {
    SRC_CORE = 2'h0,
    SRC_HOST = 2'h1,
    SRC_DEBUG = 2'h2,
    SRC_PARALLEL = 2'h3
  } access_source_type;

  typedef struct packed {
    logic valid;
    logic write;
    access_source_type source;
    logic infoBlock;
    logic specialErase;
    logic [16:0] addr;
  } flash_request_type;

  typedef struct packed {
    logic grant;
    logic reject;
    flash_op_type op;
    logic verify;
    logic bothSections;
  } flash_decision_type;

  typedef struct packed {
    logic [2:0] contentsProtect;
    logic [4:0] coreBootBlocks;
    logic [4:0] hostBootBlocks;
  } protection_limits_type;

endpackage

// ---- rtl/protection_word_loader.sv ----
/*
  Latches the protection word after reset and derives the access limits.
  Assumes the word is stable when the synchronised reset is released.
*/
`timescale 1ns/100ps
module protection_word_loader (
  input wire logic clock,
  input wire logic rstN,
  input wire logic [15:0] protectionWord,
  input wire logic [4:0] coreBootBlocksIn,
  input wire logic [4:0] hostBootBlocksIn,
  output flash_protect_pkg::protection_limits_type limits,
  output logic loaded
);

  logic [1:0] countQ;
  logic [1:0] countD;
  flash_protect_pkg::protection_limits_type limitsQ;
  flash_protect_pkg::protection_limits_type limitsD;
  logic loadedQ;
  wire logic takeNow;

  assign takeNow = !loadedQ
    && (countQ == 2'(flash_protect_pkg::PWORD_LOAD_CYCLES - 1));
  assign countD = loadedQ ? countQ : 2'(countQ + 2'h1);
  // contents protect field taken from the word on the load cycle
  assign limitsD = takeNow ? '{
      contentsProtect: protectionWord[flash_protect_pkg::CONTENTS_PROTECT_MSB:
                                      flash_protect_pkg::CONTENTS_PROTECT_LSB],
      coreBootBlocks: coreBootBlocksIn,
      hostBootBlocks: hostBootBlocksIn} : limitsQ;

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      countQ <= 2'h0;
      limitsQ <= '0;
      loadedQ <= 1'b0;
    end
    else
    begin
      countQ <= countD;
      limitsQ <= limitsD;
      loadedQ <= loadedQ | takeNow;
    end
  end

  assign limits = limitsQ;
  assign loaded = loadedQ;

endmodule

// ---- rtl/access_arbiter.sv ----
/*
  Combinational protection decision for one flash request. Assumes the
  limits are loaded and the control fields come from the register file.
*/
`timescale 1ns/100ps
module access_arbiter (
  input flash_protect_pkg::flash_request_type request,
  input flash_protect_pkg::protection_limits_type limits,
  input wire logic [15:0] blockProtect,
  input wire logic [15:0] control,
  input wire logic [15:0] hostWindow,
  input wire logic factoryArea,
  output flash_protect_pkg::flash_decision_type decision
);

  wire logic [3:0] blockIndex;
  wire logic inCoreBoot;
  wire logic inHostBoot;
  wire logic coreWritable;
  wire logic contentsOpen;
  wire logic programSel;
  wire logic pageSel;
  wire logic sectionSel;
  wire logic [1:0] selCount;
  flash_protect_pkg::flash_op_type coreOp;
  flash_protect_pkg::flash_op_type coreOpSel;

  assign blockIndex = request.addr[16:flash_protect_pkg::BLOCK_ADDR_LSB];
  // boot areas counted in blocks from the bottom and top of the array
  assign inCoreBoot = {1'b0, blockIndex} < limits.coreBootBlocks;
  assign inHostBoot = (5'h10 - {1'b0, blockIndex}) <= limits.hostBootBlocks;
  assign coreWritable = request.infoBlock ? !factoryArea
    : blockProtect[blockIndex] && !inCoreBoot && !inHostBoot;
  assign contentsOpen = limits.contentsProtect == flash_protect_pkg::CONTENTS_OPEN;

  assign programSel = control[flash_protect_pkg::PROGRAM_BIT];
  assign pageSel = control[flash_protect_pkg::PAGE_ERASE_BIT];
  assign sectionSel = control[flash_protect_pkg::SECTION_ERASE_BIT];
  assign selCount = 2'(programSel) + 2'(pageSel) + 2'(sectionSel);

  always_comb
  begin
    coreOpSel = flash_protect_pkg::OP_NONE;
    if (selCount == 2'h1)
    begin
      if (programSel)
        coreOpSel = flash_protect_pkg::OP_PROGRAM;
      else if (pageSel)
        coreOpSel = flash_protect_pkg::OP_PAGE_ERASE;
      else
        coreOpSel = flash_protect_pkg::OP_SECTION_ERASE;
    end
  end
  assign coreOp = request.specialErase ? flash_protect_pkg::OP_NONE : coreOpSel;

  always_comb
  begin
    decision = '0;
    decision.verify = !control[flash_protect_pkg::VERIFY_DISABLE_BIT];
    if (request.valid)
    begin
      unique case (request.source)
        flash_protect_pkg::SRC_CORE:
        begin
          if (!request.write)
            decision.grant = 1'b1;
          else if (coreWritable && coreOp != flash_protect_pkg::OP_NONE)
          begin
            decision.grant = 1'b1;
            decision.op = coreOp;
            decision.bothSections = request.infoBlock
              && coreOp == flash_protect_pkg::OP_SECTION_ERASE;
          end
          else
            decision.reject = 1'b1;
        end
        flash_protect_pkg::SRC_HOST:
        begin
          decision.grant = !request.infoBlock && hostWindow[blockIndex];
          decision.reject = !decision.grant;
          decision.op = (decision.grant && request.write)
            ? flash_protect_pkg::OP_PROGRAM : flash_protect_pkg::OP_NONE;
        end
        flash_protect_pkg::SRC_DEBUG, flash_protect_pkg::SRC_PARALLEL:
        begin
          if (request.specialErase)
          begin
            decision.grant = 1'b1;
            decision.op = flash_protect_pkg::OP_SPECIAL_ERASE;
          end
          else if (contentsOpen && !(request.write && factoryArea))
          begin
            decision.grant = 1'b1;
            decision.op = request.write ? flash_protect_pkg::OP_PROGRAM
              : flash_protect_pkg::OP_NONE;
          end
          else
            decision.reject = 1'b1;
        end
      endcase
    end
  end

endmodule

// ---- verification/embedded_flash_protect_control_props.sv ----
/*
  Port checks for the flash protection block.
  Assumes one clock and word-wide protect writes.
*/
`timescale 1ns/100ps
module embedded_flash_protect_control_props (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [23:0] regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regReadData,
  input flash_protect_pkg::flash_request_type request,
  input flash_protect_pkg::flash_decision_type decision,
  input wire logic writeViolation,
  input wire logic [15:0] protectionWord,
  input wire logic [4:0] coreBootBlocks,
  input wire logic limitsLoaded,
  input wire logic verifyEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] protShadow_q;
  wire logic coreReq = request.valid && request.source == flash_protect_pkg::SRC_CORE;
  wire logic coreWr = coreReq && request.write;
  wire logic protWr = regWrite && regAddr == flash_protect_pkg::CORE_BLOCK_WRITE_PROTECT_ADDR;
  // shadow of the block protect register
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      protShadow_q <= 16'h0000;
    else if (protWr)
      protShadow_q <= regWriteData;
  sequence rdCtl;
    regRead && regAddr == flash_protect_pkg::FLASH_OPERATION_CONTROL_ADDR;
  endsequence
  sequence rdIdx;
    regRead && regAddr == flash_protect_pkg::INFO_BLOCK_INDEX_ADDR;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_core_read_open: assert property (coreReq && !request.write && limitsLoaded |-> decision.grant)
    else $error("core read not granted");
  a_prot_bit_gate: assert property (coreWr && !request.infoBlock &&
    !protShadow_q[request.addr[16:13]] |-> !decision.grant && writeViolation)
    else $error("protected block write not refused");
  a_boot_block_locked: assert property (coreWr && !request.infoBlock &&
    {1'b0, request.addr[16:13]} < coreBootBlocks |-> !decision.grant)
    else $error("core boot block writable");
  a_factory_locked: assert property (coreWr && request.infoBlock && request.addr[7]
    |-> !decision.grant)
    else $error("factory area writable by core");
  a_core_no_special: assert property (coreWr && request.specialErase |-> !decision.grant)
    else $error("core special erase granted");
  a_debug_closed: assert property (request.valid &&
    request.source == flash_protect_pkg::SRC_DEBUG && !request.specialErase &&
    protectionWord[9:7] != 3'h7 |-> !decision.grant)
    else $error("debug granted while protected");
  a_ctrl_reserved: assert property (rdCtl |=> (regReadData & ~flash_protect_pkg::CONTROL_WRITE_MASK)
    == 16'h0000)
    else $error("control reserved bits not zero");
  a_index_upper_zero: assert property (rdIdx |=> regReadData[15:8] == 8'h00)
    else $error("index upper byte not zero");
  a_verify_follows: assert property (coreWr && decision.grant |-> decision.verify == verifyEnable)
    else $error("verify does not follow control");
  a_single_op: assert property (coreWr && decision.grant |-> decision.op inside
    {flash_protect_pkg::OP_PROGRAM, flash_protect_pkg::OP_PAGE_ERASE,
    flash_protect_pkg::OP_SECTION_ERASE})
    else $error("core write op not single");
endmodule
bind embedded_flash_protect_control embedded_flash_protect_control_props props (.clock, .nrst,
  .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .request, .decision,
  .writeViolation, .protectionWord, .coreBootBlocks, .limitsLoaded, .verifyEnable);

// ---- verification/embedded_flash_protect_control_tb.sv ----
/*
  Self-checking bench for the flash protection block.
  Assumes the package constants and a one-cycle register port.
*/
`timescale 1ns/100ps
module embedded_flash_protect_control_tb;
  import flash_protect_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [23:0] regAddr = 24'h000000;
  logic [15:0] regWriteData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic regByte = 1'b0;
  logic [15:0] regReadData, infoWriteData;
  logic regWordFault, writeViolation, holdInReset, limitsLoaded, infoWrite, infoRead, infoByte;
  logic flashLowPower, bufferIrq, verifyEnable;
  logic [7:0] infoAddr;
  flash_request_type request = '0;
  flash_decision_type decision;
  logic [15:0] protectionWord = 16'h0380;
  logic [4:0] coreBootBlocks = 5'h02;
  logic [4:0] hostBootBlocks = 5'h02;
  logic [15:0] hostWindow;
  logic debugEnvironment = 1'b0;
  logic specialEraseDone = 1'b0;
  logic hostLock = 1'b0;
  logic doubleBufferFull = 1'b1;
  logic [15:0] infoReadData = 16'h0000;
  int badCount = 0;
  int checkCount = 0;
  int cycles = 0;
  int seed = 31622;
  logic [15:0] prot, rnd;
  logic [15:0] modeCtl [8] = '{16'h0020, 16'h0120, 16'h0040, 16'h0080, 16'h0060, 16'h00A0,
    16'h00E0, 16'h0000};
  logic [2:0] modeOp [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0};
  embedded_flash_protect_control DUT (.clock, .nrst, .regAddr, .regWriteData, .regWrite,
    .regRead, .regByte, .regReadData, .regWordFault, .request, .decision, .writeViolation,
    .protectionWord, .coreBootBlocks, .hostBootBlocks, .hostWindow, .debugEnvironment,
    .specialEraseDone, .holdInReset, .limitsLoaded, .hostLock, .doubleBufferFull,
    .infoReadData, .infoAddr, .infoWriteData, .infoWrite, .infoRead, .infoByte,
    .flashLowPower, .bufferIrq, .verifyEnable);
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      badCount++;
      $display("unexpected at %0t: run too long", $time);
      results();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checkCount++;
    if (got !== exp)
    begin
      badCount++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic access(input logic [23:0] a, input logic [15:0] d, input logic b, input logic w);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regByte <= b;
    regWrite <= w;
    regRead <= !w;
    @(posedge clock);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [23:0] a, input logic b, input logic [15:0] exp, input string s);
    access(a, 16'h0000, b, 1'b0);
    check(regReadData, exp, s);
  endtask
  task automatic wc(input logic [15:0] d);
    access(FLASH_OPERATION_CONTROL_ADDR, d, 1'b0, 1'b1);
  endtask
  task automatic req(input logic w, input access_source_type s, input logic ib, input logic sp,
    input logic [16:0] a, input logic g, input string what);
    @(posedge clock);
    request <= '{valid: 1'b1, write: w, source: s, infoBlock: ib, specialErase: sp, addr: a};
    @(negedge clock);
    check(decision.grant, g, what);
  endtask
  function automatic logic blockOk(input logic [15:0] p, input int i);
    return p[i] && i >= coreBootBlocks && i < 16 - hostBootBlocks;
  endfunction
  task automatic doReset(input logic [15:0] pw);
    request <= '0;
    nrst <= 1'b0;
    protectionWord <= pw;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    check(limitsLoaded, 1'b1, "limits loaded");
    repeat (2) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hostWindow = $random(seed);
    doReset(16'h0380);
    rd(CORE_BLOCK_WRITE_PROTECT_ADDR, 1'b0, 16'h0000, "protect reset");
    rd(FLASH_OPERATION_CONTROL_ADDR, 1'b0, 16'h0000, "control reset");
    rd(24'h00F884, 1'b0, 16'h0000, "unmapped read");
    $display("test reset values done");
    rnd = $random(seed);
    wc(rnd);
    rd(FLASH_OPERATION_CONTROL_ADDR, 1'b0, rnd & 16'h01F1, "control readback");
    check(verifyEnable, !rnd[8], "verify enable");
    check(flashLowPower, rnd[0], "low power");
    wc(16'h0010);
    check(bufferIrq, 1'b0, "irq while full");
    doubleBufferFull <= 1'b0;
    repeat (3) @(negedge clock);
    check(bufferIrq, 1'b1, "irq when not full");
    wc(16'h0000);
    check(bufferIrq, 1'b0, "irq disabled");
    hostLock <= 1'b1;
    repeat (3) @(negedge clock);
    wc(16'h0101);
    rd(FLASH_OPERATION_CONTROL_ADDR, 1'b0, 16'h0000, "locked control write");
    hostLock <= 1'b0;
    repeat (3) @(negedge clock);
    $display("test control done");
    wc(16'h0020);
    for (int p = 0; p < 2; p++)
    begin
      prot = (p == 0) ? 16'($random(seed)) : 16'hFFFF;
      access(CORE_BLOCK_WRITE_PROTECT_ADDR, prot, 1'b0, 1'b1);
      rd(CORE_BLOCK_WRITE_PROTECT_ADDR, 1'b0, prot, "protect readback");
      for (int i = 0; i < 16; i++)
      begin
        req(1'b1, SRC_CORE, 1'b0, 1'b0, {i[3:0], 13'h0ABC}, blockOk(prot, i), "block gate");
        check(writeViolation, !blockOk(prot, i), "violation flag");
      end
    end
    $display("test block protect done");
    for (int m = 0; m < 8; m++)
    begin
      wc(modeCtl[m]);
      req(1'b1, SRC_CORE, 1'b0, 1'b0, 17'h0A000, modeOp[m] != 3'h0, "mode grant");
      check(decision.op, modeOp[m], "mode op");
      if (modeOp[m] != 3'h0)
        check(decision.verify, !modeCtl[m][8], "mode verify");
    end
    wc(16'h0080);
    req(1'b1, SRC_CORE, 1'b1, 1'b0, 17'h00010, 1'b1, "info section erase");
    check(decision.bothSections, 1'b1, "both sections");
    wc(16'h0020);
    req(1'b1, SRC_CORE, 1'b1, 1'b0, 17'h00080, 1'b0, "factory write");
    access(CORE_BLOCK_WRITE_PROTECT_ADDR, 16'h0000, 1'b0, 1'b1);
    req(1'b0, SRC_CORE, 1'b0, 1'b0, 17'h0A000, 1'b1, "core read");
    req(1'b1, SRC_CORE, 1'b0, 1'b1, 17'h0A000, 1'b0, "core special");
    req(1'b0, SRC_HOST, 1'b1, 1'b0, 17'h00010, 1'b0, "host info read");
    req(1'b0, SRC_DEBUG, 1'b0, 1'b0, 17'h1E000, 1'b1, "debug read open");
    req(1'b1, SRC_DEBUG, 1'b0, 1'b0, 17'h00000, 1'b1, "debug write open");
    req(1'b1, SRC_DEBUG, 1'b1, 1'b0, 17'h00080, 1'b0, "debug factory write");
    $display("test sources done");
    access(INFO_BLOCK_INDEX_ADDR, 16'hFF11, 1'b0, 1'b1);
    rd(INFO_BLOCK_INDEX_ADDR, 1'b0, 16'h0011, "index readback");
    rnd = $random(seed);
    access(INFO_BLOCK_DATA_ADDR, rnd, 1'b0, 1'b1);
    check(regWordFault, 1'b1, "odd word fault");
    check(infoWrite, 1'b0, "odd word ignored");
    access(INFO_BLOCK_DATA_ADDR, rnd, 1'b1, 1'b1);
    check({infoWrite, infoByte, infoAddr}, {2'b11, 8'h11}, "byte write");
    check(infoWriteData[7:0], rnd[7:0], "byte write data");
    access(INFO_BLOCK_INDEX_ADDR, 16'h0010, 1'b0, 1'b1);
    rnd = $random(seed);
    infoReadData <= rnd;
    rd(INFO_BLOCK_DATA_ADDR, 1'b0, rnd, "word read");
    rd(INFO_BLOCK_DATA_ADDR, 1'b1, {8'h00, infoReadData[7:0]}, "byte read");
    $display("test info window done");
    debugEnvironment <= 1'b1;
    doReset(16'h0300);
    req(1'b0, SRC_DEBUG, 1'b0, 1'b0, 17'h1E000, 1'b0, "debug read closed");
    check(holdInReset, 1'b1, "held in reset");
    req(1'b1, SRC_DEBUG, 1'b0, 1'b1, 17'h00000, 1'b1, "debug special");
    check(decision.op, OP_SPECIAL_ERASE, "special op");
    req(1'b0, SRC_PARALLEL, 1'b0, 1'b0, 17'h00000, 1'b0, "parallel read closed");
    req(1'b1, SRC_PARALLEL, 1'b0, 1'b1, 17'h00000, 1'b1, "parallel special");
    specialEraseDone <= 1'b1;
    req(1'b0, SRC_DEBUG, 1'b0, 1'b0, 17'h1E000, 1'b0, "debug still closed");
    repeat (3) @(negedge clock);
    check(holdInReset, 1'b0, "released after erase");
    $display("test protected word done");
    results();
  end
endmodule
